// >>> design/dqt_pkg.sv
// shared constants and types for the dq calibration and training fifo block
package dqt_pkg;

  localparam int DQ_W = 16;
  localparam int DMI_W = 2;
  localparam int LANE_W = 18;
  localparam int BEAT_W = 4;
  localparam int BURST_LEN = 16;
  localparam int FIFO_DEPTH = 5;
  localparam int PTR_W = 3;
  localparam int ADDR_W = 7;
  localparam int MEM_WORDS = 80;
  localparam int LAT_W = 6;
  localparam int LINE_DEPTH = 64;

  // beat offsets of the two read-line taps relative to the latency
  localparam logic [LAT_W-1:0] DATA_TAP_OFS = 6'h01;
  localparam logic [LAT_W-1:0] PRE_TAP_OFS = 6'h03;
  localparam logic [BEAT_W-1:0] LAST_BEAT = 4'hf;
  localparam logic [PTR_W-1:0] LAST_PTR = 3'h4;

  // mode register reset values
  localparam logic [7:0] PAT_FIRST_RST = 8'h5a;
  localparam logic [7:0] PAT_SECOND_RST = 8'h3c;
  localparam logic [7:0] INV_LO_RST = 8'h55;
  localparam logic [7:0] INV_HI_RST = 8'h55;
  localparam logic [7:0] DM_CTL_RST = 8'h00;
  localparam logic [7:0] IO_INV_RST = 8'h00;

  // field positions
  localparam int MPC_EN_BIT = 6;
  localparam int DM_DIS_BIT = 5;
  localparam int WDBI_BIT = 7;
  localparam int RDBI_BIT = 6;

  // training function codes in operand bits 5..0
  localparam logic [5:0] FN_RDFIFO = 6'h01;
  localparam logic [5:0] FN_RDCAL = 6'h03;
  localparam logic [5:0] FN_WRFIFO = 6'h07;

  typedef enum logic [3:0] {
    CMD_MPC = 4'h0,
    CMD_CAS2 = 4'h1,
    CMD_WRITE = 4'h2,
    CMD_MWRITE = 4'h3,
    CMD_READ = 4'h4,
    CMD_MRR = 4'h5,
    CMD_PDE = 4'h6,
    CMD_SRPDE = 4'h7,
    CMD_OTHER = 4'h8
  } dqt_cmd_e;

  typedef enum logic [2:0] {
    MR_PAT_FIRST = 3'h0,
    MR_PAT_SECOND = 3'h1,
    MR_INV_LO = 3'h2,
    MR_INV_HI = 3'h3,
    MR_DM_CTL = 3'h4,
    MR_IO_INV = 3'h5
  } dqt_mr_e;

  typedef enum logic [1:0] {
    OP_NONE = 2'h0,
    OP_RDCAL = 2'h1,
    OP_RDFIFO = 2'h2,
    OP_WRFIFO = 2'h3
  } dqt_op_e;

  typedef enum logic [1:0] {
    BST_IDLE = 2'h0,
    BST_PRE = 2'h1,
    BST_DATA = 2'h2,
    BST_POST = 2'h3
  } dqt_burst_e;

endpackage

// >>> design/dqt_fifo_mem.sv
// storage of the training fifo: five bursts of sixteen 18-bit beats
`timescale 1ns/1ns
module dqt_fifo_mem
  import dqt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [dqt_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [dqt_pkg::LANE_W-1:0] wr_data,
  input wire logic [dqt_pkg::ADDR_W-1:0] rd_addr,
  output logic [dqt_pkg::LANE_W-1:0] rd_data
);

  logic [LANE_W-1:0] word_q [MEM_WORDS];

  // reading never alters storage
  assign rd_data = (rd_addr < ADDR_W'(MEM_WORDS)) ? word_q[rd_addr] : '0;

  for (genvar w = 0; w < MEM_WORDS; w++) begin : g_word
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        word_q[w] <= '0;
      end else if (wr_en && wr_addr == ADDR_W'(w)) begin
        word_q[w] <= wr_data;
      end
    end
  end

endmodule

// >>> design/dqt_train.sv
// read dq calibration and write/read dq training fifo, device side
// Function
// - calibration commands at burst spacing each give a fresh burst
// - calibration data uses ordinary read latency and strobe timing
// - burst is 16 beats, toggling preamble, half-clock postamble
// - every lane sends first pattern byte then second, lsb first
// - pattern inverted on masked data pins, never on data-mask lanes
// - low mask bits map to DQ0-7, high mask bits to DQ8-15
// - data-mask lanes float only if mask and both inversions disabled
// - no bus inversion is applied to the calibration burst
// - multi-purpose command is a no-op when operand bit 6 is low
// - fifo writes use write latency from CAS-2 second edge
// - fifo holds five bursts, 80 values per pin
// - fifo reads use read latency from CAS-2 second edge
// - fifo reads are non-destructive
// - unwritten entries read back undefined but valid data
// - successive fifo reads step entries one to five then wrap
// - fifo write moves write pointer, fifo read read pointer, read both
// - pointers clear on power-up, reset pin, power-down, self-refresh entry
`timescale 1ns/1ns
module dqt_train
  import dqt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic cmd_valid,
  input wire dqt_pkg::dqt_cmd_e cmd_kind,
  input wire logic [6:0] cmd_op,
  input wire logic mrw_valid,
  input wire dqt_pkg::dqt_mr_e mrw_sel,
  input wire logic [7:0] mrw_data,
  input wire logic [dqt_pkg::LAT_W-1:0] read_latency,
  input wire logic [dqt_pkg::LAT_W-1:0] write_latency,
  input wire logic [dqt_pkg::DQ_W-1:0] dq_in,
  input wire logic [dqt_pkg::DMI_W-1:0] dmi_in,
  output logic [dqt_pkg::DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic [dqt_pkg::DMI_W-1:0] dmi_out,
  output logic dmi_oe,
  output logic dqs_out,
  output logic dqs_oe,
  output logic [dqt_pkg::PTR_W-1:0] wr_ptr,
  output logic [dqt_pkg::PTR_W-1:0] rd_ptr
);
  import dqt_pkg::*;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + 3'h1;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // reset pin synchroniser and mode registers
  logic [2:0] rpin_q;
  logic rpin_hit;
  logic [7:0] pat1_q, pat2_q, inv_lo_q, inv_hi_q, dm_ctl_q, io_inv_q;

  // stages two and three must agree
  assign rpin_hit = !rpin_q[1] && !rpin_q[2];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rpin_q <= 3'h7;
    end else begin
      rpin_q <= {rpin_q[1:0], reset_pin_n};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || rpin_hit) begin
      pat1_q <= PAT_FIRST_RST;
      pat2_q <= PAT_SECOND_RST;
      inv_lo_q <= INV_LO_RST;
      inv_hi_q <= INV_HI_RST;
      dm_ctl_q <= DM_CTL_RST;
      io_inv_q <= IO_INV_RST;
    end else if (mrw_valid) begin
      unique case (mrw_sel)
        MR_PAT_FIRST: pat1_q <= mrw_data;
        MR_PAT_SECOND: pat2_q <= mrw_data;
        MR_INV_LO: inv_lo_q <= mrw_data;
        MR_INV_HI: inv_hi_q <= mrw_data;
        MR_DM_CTL: dm_ctl_q <= mrw_data;
        MR_IO_INV: io_inv_q <= mrw_data;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // command decode and fifo pointers
  dqt_op_e mpc_op, pend_q, pend_d;
  logic is_mpc, is_cas2, go, arr_read, ptr_clr, adv_wr, adv_rd;
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q, wr_ptr_d, rd_ptr_d;

  assign is_mpc = cmd_valid && cmd_kind == CMD_MPC;
  assign is_cas2 = cmd_valid && cmd_kind == CMD_CAS2;
  // operand bit 6 low makes the command a no-op
  assign mpc_op = !cmd_op[MPC_EN_BIT] ? OP_NONE :
                  (cmd_op[5:0] == FN_RDCAL) ? OP_RDCAL :
                  (cmd_op[5:0] == FN_RDFIFO) ? OP_RDFIFO :
                  (cmd_op[5:0] == FN_WRFIFO) ? OP_WRFIFO : OP_NONE;
  // any other command between the pair cancels it
  assign pend_d = is_mpc ? mpc_op : (cmd_valid ? OP_NONE : pend_q);
  assign go = is_cas2 && pend_q != OP_NONE;
  assign arr_read = cmd_valid && cmd_kind == CMD_READ;
  assign ptr_clr = rpin_hit || (cmd_valid &&
                   (cmd_kind == CMD_PDE || cmd_kind == CMD_SRPDE));
  assign adv_wr = (go && pend_q == OP_WRFIFO) || arr_read;
  assign adv_rd = (go && pend_q == OP_RDFIFO) || arr_read;
  assign wr_ptr_d = ptr_clr ? '0 : (adv_wr ? ptr_inc(wr_ptr_q) : wr_ptr_q);
  assign rd_ptr_d = ptr_clr ? '0 : (adv_rd ? ptr_inc(rd_ptr_q) : rd_ptr_q);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_q <= OP_NONE;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      pend_q <= pend_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  assign wr_ptr = wr_ptr_q;
  assign rd_ptr = rd_ptr_q;

  //////////////////////////////////////////////////////////////////////////
  // latency lines: element 0 loads on the CAS-2 cycle
  logic [LINE_DEPTH-1:0][4:0] rline_q;
  logic [LINE_DEPTH-1:0][3:0] wline_q;
  logic [4:0] rline_new, rtap_dat, rtap_pre;
  logic [3:0] wline_new, wtap;

  assign rline_new = (go && (pend_q == OP_RDCAL || pend_q == OP_RDFIFO)) ?
                     {pend_q, rd_ptr_q} : '0;
  assign wline_new = (go && pend_q == OP_WRFIFO) ? {1'b1, wr_ptr_q} : '0;
  assign rtap_dat = rline_q[read_latency - DATA_TAP_OFS];
  assign rtap_pre = rline_q[read_latency - PRE_TAP_OFS];
  assign wtap = wline_q[write_latency];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rline_q <= '0;
      wline_q <= '0;
    end else begin
      rline_q <= {rline_q[LINE_DEPTH-2:0], rline_new};
      wline_q <= {wline_q[LINE_DEPTH-2:0], wline_new};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write capture into the fifo
  logic wact_q, wr_en;
  logic [BEAT_W-1:0] wbeat_q, wbeat;
  logic [PTR_W-1:0] went_q, went;

  assign wr_en = wtap[3] || wact_q;
  assign wbeat = wtap[3] ? '0 : wbeat_q;
  assign went = wtap[3] ? wtap[2:0] : went_q;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wact_q <= 1'b0;
      wbeat_q <= '0;
      went_q <= '0;
    end else begin
      wact_q <= wtap[3] || (wact_q && wbeat_q != LAST_BEAT);
      wbeat_q <= wbeat + 4'h1;
      went_q <= went;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read burst sequencer
  dqt_burst_e bst_q, bst_d;
  logic [BEAT_W-1:0] beat_q, beat_d;
  dqt_op_e rop_q, rop_d;
  logic [PTR_W-1:0] rent_q, rent_d;
  logic [LANE_W-1:0] mem_rd;

  always_comb begin
    bst_d = BST_IDLE;
    beat_d = '0;
    rop_d = rop_q;
    rent_d = rent_q;
    if (rtap_dat[4:3] != OP_NONE) begin
      bst_d = BST_DATA;
      rop_d = dqt_op_e'(rtap_dat[4:3]);
      rent_d = rtap_dat[2:0];
    end else if (bst_q == BST_DATA && beat_q != LAST_BEAT) begin
      bst_d = BST_DATA;
      beat_d = beat_q + 4'h1;
    end else if (bst_q == BST_DATA) begin
      bst_d = BST_POST;
    end else if (bst_q == BST_PRE || rtap_pre[4:3] != OP_NONE) begin
      bst_d = BST_PRE;
      beat_d = (bst_q == BST_PRE) ? beat_q + 4'h1 : '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bst_q <= BST_IDLE;
      beat_q <= '0;
      rop_q <= OP_NONE;
      rent_q <= '0;
    end else begin
      bst_q <= bst_d;
      beat_q <= beat_d;
      rop_q <= rop_d;
      rent_q <= rent_d;
    end
  end

  dqt_fifo_mem u_mem (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .wr_en(wr_en),
    .wr_addr({went, wbeat}),
    .wr_data({dmi_in, dq_in}),
    .rd_addr({rent_q, beat_q}),
    .rd_data(mem_rd)
  );

  //////////////////////////////////////////////////////////////////////////
  // lane data selection and output flops
  logic pat_bit, is_fifo, in_data, dmi_drive;
  logic [DQ_W-1:0] inv_mask, lane_d;
  logic [DMI_W-1:0] dmi_d;

  assign pat_bit = beat_q[3] ? pat2_q[beat_q[2:0]] :
                   pat1_q[beat_q[2:0]];
  assign inv_mask = {inv_hi_q, inv_lo_q};
  assign is_fifo = rop_q == OP_RDFIFO;
  assign in_data = bst_q == BST_DATA;
  // no bus inversion term enters the calibration path
  assign dmi_d = is_fifo ? mem_rd[LANE_W-1:DQ_W] :
                 {DMI_W{pat_bit}};
  assign dmi_drive = !(dm_ctl_q[DM_DIS_BIT] && !io_inv_q[WDBI_BIT] &&
                       !io_inv_q[RDBI_BIT]);

  for (genvar i = 0; i < DQ_W; i++) begin : g_lane
    assign lane_d[i] = is_fifo ? mem_rd[i] :
                       (pat_bit ^ inv_mask[i]);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dq_out <= '0;
      dq_oe <= 1'b0;
      dmi_out <= '0;
      dmi_oe <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
    end else begin
      dq_out <= in_data ? lane_d : '0;
      dq_oe <= in_data;
      dmi_out <= in_data ? dmi_d : '0;
      dmi_oe <= in_data && dmi_drive;
      dqs_out <= (bst_q == BST_PRE || in_data) ? beat_q[0] : 1'b0;
      dqs_oe <= bst_q != BST_IDLE;
    end
  end

endmodule

// >>> test/dqt_train_props.sv
// port assertions for the training block
`timescale 1ns/1ns
module dqt_train_props
  import dqt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire dqt_pkg::dqt_cmd_e cmd_kind,
  input wire logic [6:0] cmd_op,
  input wire logic [dqt_pkg::LAT_W-1:0] read_latency,
  input wire logic dq_oe,
  input wire logic dmi_oe,
  input wire logic dqs_out,
  input wire logic dqs_oe,
  input wire logic [dqt_pkg::PTR_W-1:0] wr_ptr,
  input wire logic [dqt_pkg::PTR_W-1:0] rd_ptr
);
  logic rd_q;
  logic [dqt_pkg::LAT_W-1:0] lat_q;
  wire mpc = cmd_valid && cmd_kind == CMD_MPC;
  wire rd_mpc = mpc && cmd_op[6] &&
    (cmd_op[5:0] == FN_RDCAL || cmd_op[5:0] == FN_RDFIFO);
  wire cas = cmd_valid && cmd_kind == CMD_CAS2;
  function automatic logic [2:0] nxt(input logic [2:0] p);
    return p == LAST_PTR ? 3'h0 : p + 3'h1;
  endfunction
  // read latency countdown from the cas-2 after a read type mpc
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_q <= 1'b0;
      lat_q <= '0;
    end else begin
      rd_q <= rd_mpc;
      lat_q <= rd_q && cas ? read_latency : (lat_q != '0 ? lat_q - 1'b1 : '0);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_pre;
    dqs_oe && !dq_oe && !dqs_out ##1 dqs_oe && !dq_oe && dqs_out ##1 dq_oe;
  endsequence
  sequence s_post;
    dqs_oe && !dqs_out && !dq_oe ##1 !dqs_oe;
  endsequence
  a_pre_two: assert property ($rose(dqs_oe) |-> s_pre)
    else $error("preamble not two toggling beats");
  a_post_half: assert property ($fell(dq_oe) |-> s_post)
    else $error("postamble not one beat");
  // countdown ends one cycle before the burst flop, two before the pins
  a_rd_latency: assert property (lat_q == 'd1 |-> ##2 dq_oe)
    else $error("burst late");
  a_strobe_data: assert property (dq_oe |-> dqs_oe)
    else $error("strobe off in burst");
  a_dmi_burst: assert property (dmi_oe |-> dq_oe)
    else $error("dmi driven outside burst");
  a_mpc_nop: assert property (mpc && !cmd_op[6] |=>
    ($stable(wr_ptr) && $stable(rd_ptr))[*3])
    else $error("nop moved pointers");
  a_ptr_clear: assert property (cmd_valid &&
    (cmd_kind == CMD_PDE || cmd_kind == CMD_SRPDE) |=>
    wr_ptr == '0 && rd_ptr == '0)
    else $error("pointers not cleared");
  a_read_both: assert property (cmd_valid &&
    cmd_kind == CMD_READ |=>
    wr_ptr == nxt($past(wr_ptr)) && rd_ptr == nxt($past(rd_ptr)))
    else $error("read did not step pointers");
  a_ptr_range: assert property (
    wr_ptr <= LAST_PTR && rd_ptr <= LAST_PTR)
    else $error("pointer out of range");
  cover property (lat_q == 'd1);
endmodule

bind dqt_train dqt_train_props i_dqt_train_props (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
  .cmd_kind(cmd_kind), .cmd_op(cmd_op), .read_latency(read_latency),
  .dq_oe(dq_oe), .dmi_oe(dmi_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
  .wr_ptr(wr_ptr), .rd_ptr(rd_ptr)
);

// >>> test/dqt_ctl_model.sv
// controller command model: mpc followed by cas-2 unless go is raised again the next cycle
`timescale 1ns/1ns
module dqt_ctl_model
  import dqt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire dqt_pkg::dqt_cmd_e go_kind,
  input wire logic [6:0] go_op,
  output logic cmd_valid,
  output dqt_pkg::dqt_cmd_e cmd_kind,
  output logic [6:0] cmd_op
);
  logic cas_q;
  always_ff @(posedge sys_clk) begin
    cas_q <= !sys_rst && go && go_kind == CMD_MPC;
    cmd_valid <= !sys_rst && (go || cas_q);
    cmd_kind <= go ? go_kind : CMD_CAS2;
    // idle operands keep changing so stale values never look valid
    cmd_op <= go ? go_op : (cas_q ? 7'h00 : ~cmd_op);
  end
endmodule

// >>> test/dqt_train_test.sv
// self-checking bench for the training block
`timescale 1ns/1ns
module dqt_train_test;
  import dqt_pkg::*;
  localparam int RL = 8;
  localparam int WL = 5;
  // issue call to first data beat: mpc, cas-2, latency line, burst flop, output flop
  localparam int FIRST_BEAT = RL + 4;
  // controller idle time after power-down before calibration
  localparam int PD_EXIT_WAIT = 8;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic go = 1'b0;
  dqt_cmd_e go_kind = CMD_OTHER;
  logic [6:0] go_op = 7'h00;
  logic mrw_valid = 1'b0;
  dqt_mr_e mrw_sel = MR_PAT_FIRST;
  logic [7:0] mrw_data = 8'h00;
  logic [15:0] dq_in = 16'h0000;
  logic [1:0] dmi_in = 2'h0;
  logic cmd_valid, dq_oe, dmi_oe, dqs_out, dqs_oe;
  dqt_cmd_e cmd_kind;
  logic [6:0] cmd_op;
  logic [15:0] dq_out;
  logic [1:0] dmi_out;
  logic [2:0] wr_ptr, rd_ptr;
  logic [7:0] mr [6];
  logic [17:0] mem [5][16];
  logic [17:0] exp_b [$];
  int wp, rp, c, errors, checks_done;
  dqt_ctl_model i_dqt_ctl_model (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .go(go), .go_kind(go_kind), .go_op(go_op), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_op(cmd_op));
  dqt_train i_dqt_train (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reset_pin_n(reset_pin_n), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_op(cmd_op), .mrw_valid(mrw_valid), .mrw_sel(mrw_sel),
    .mrw_data(mrw_data), .read_latency(6'(RL)), .write_latency(6'(WL)),
    .dq_in(dq_in), .dmi_in(dmi_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .dmi_out(dmi_out), .dmi_oe(dmi_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
    .wr_ptr(wr_ptr), .rd_ptr(rd_ptr));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // new beat each cycle, held stable across the device's sampling edge
  always @(posedge sys_clk) begin
    dq_in <= 16'($urandom);
    dmi_in <= 2'($urandom);
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [17:0] g,
    input logic [17:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  function automatic void mdef();
    mr = '{PAT_FIRST_RST, PAT_SECOND_RST, INV_LO_RST, INV_HI_RST,
      DM_CTL_RST, IO_INV_RST};
  endfunction
  function automatic void push_cal();
    logic b;
    for (int i = 0; i < 16; i++) begin
      b = i < 8 ? mr[MR_PAT_FIRST][i] : mr[MR_PAT_SECOND][i - 8];
      exp_b.push_back({{2{b}}, {16{b}} ^ {mr[MR_INV_HI], mr[MR_INV_LO]}});
    end
  endfunction
  task automatic issue(input dqt_cmd_e k, input logic [6:0] op);
    go <= 1'b1;
    go_kind <= k;
    go_op <= op;
    @(posedge sys_clk);
    go <= 1'b0;
  endtask
  task automatic mrw(input dqt_mr_e s, input logic [7:0] d);
    mrw_valid <= 1'b1;
    mrw_sel <= s;
    mrw_data <= d;
    mr[s] = d;
    @(posedge sys_clk);
    mrw_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic chkp();
    repeat (2) @(posedge sys_clk);
    chk("wr_ptr", wr_ptr, wp);
    chk("rd_ptr", rd_ptr, rp);
  endtask
  task automatic grab(input int lat, input int n);
    logic eo;
    logic [17:0] m;
    eo = !(mr[MR_DM_CTL][DM_DIS_BIT] && !mr[MR_IO_INV][WDBI_BIT] &&
      !mr[MR_IO_INV][RDBI_BIT]);
    m = {{2{eo}}, 16'hffff};
    c = 1;
    @(negedge sys_clk);
    while (dq_oe !== 1'b1 && c < 100) begin
      @(posedge sys_clk);
      c++;
      @(negedge sys_clk);
    end
    if (c >= 100) begin
      errors++;
      test_done();
    end
    chk("latency", c, lat);
    for (int i = 0; i < n; i++) begin
      chk("beat", {dmi_out, dq_out} & m,
        exp_b.pop_front() & m);
      chk("dmi_oe", dmi_oe, eo);
      chk("dq_oe", dq_oe, 1'b1);
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
  endtask
  task automatic cal();
    push_cal();
    issue(CMD_MPC, {1'b1, FN_RDCAL});
    grab(FIRST_BEAT, 16);
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic wrf();
    issue(CMD_MPC, {1'b1, FN_WRFIFO});
    repeat (WL + 2) @(posedge sys_clk);
    for (int i = 0; i < 16; i++) begin
      @(negedge sys_clk);
      mem[wp][i] = {dmi_in, dq_in};
      @(posedge sys_clk);
    end
    wp = (wp + 1) % 5;
    chkp();
  endtask
  task automatic rdf();
    for (int i = 0; i < 16; i++) exp_b.push_back(mem[rp][i]);
    rp = (rp + 1) % 5;
    issue(CMD_MPC, {1'b1, FN_RDFIFO});
    grab(FIRST_BEAT, 16);
    chkp();
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h115f_348e));
    mdef();
    foreach (mem[i, j]) mem[i][j] = '0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    cal();
    tend("defaults");
    for (int i = 0; i < 8; i++) begin
      for (int j = 0; j < 4; j++) mrw(dqt_mr_e'(j), 8'($urandom));
      mrw(MR_DM_CTL, {2'b00, i[0], 5'h00});
      mrw(MR_IO_INV, {i[2:1], 6'h00});
      cal();
    end
    tend("pattern");
    push_cal();
    push_cal();
    issue(CMD_MPC, {1'b1, FN_RDCAL});
    fork
      grab(FIRST_BEAT, 32);
      begin
        repeat (15) @(posedge sys_clk);
        issue(CMD_MPC, {1'b1, FN_RDCAL});
      end
    join
    tend("seamless");
    rdf();
    issue(CMD_PDE, 7'h00);
    wp = 0;
    rp = 0;
    chkp();
    repeat (PD_EXIT_WAIT) @(posedge sys_clk);
    cal();
    repeat (6) wrf();
    repeat (6) rdf();
    tend("fifo");
    for (int i = 0; i < 3; i++) begin
      issue(i == 1 ? CMD_SRPDE : CMD_READ, 7'h00);
      wp = i == 1 ? 0 : (wp + 1) % 5;
      rp = i == 1 ? 0 : (rp + 1) % 5;
      chkp();
    end
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    mdef();
    wp = 0;
    rp = 0;
    chkp();
    cal();
    tend("pointers");
    issue(CMD_MPC, {1'b0, FN_RDCAL});
    repeat (3) @(posedge sys_clk);
    issue(CMD_MPC, 7'h7f);
    c = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (dq_oe !== 1'b0) c++;
    end
    chk("nop", c, 0);
    chkp();
    tend("nop");
    test_done();
  end
endmodule
